/* rtl/rcs_defs.vh */
`ifndef RCS_DEFS_VH
`define RCS_DEFS_VH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define RCS_CSR_OFFSET      8'h38
`define RCS_CSR_RESET       32'h0800_0000
`define RCS_ADDR_W          8

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RCS_LOW_POWER_BIT   31
`define RCS_WATCHDOG_BIT    29
`define RCS_SOFTWARE_BIT    28
`define RCS_POWER_ON_BIT    27
`define RCS_PIN_BIT         26
`define RCS_REMOVE_BIT      24
`define RCS_LOCKUP_BIT      23
`define RCS_VDET_BIT        22
`define RCS_LOCKUP_EN_BIT   7
`define RCS_VDET_EN_BIT     6
`define RCS_LSO_RDY_BIT     1
`define RCS_LSO_ON_BIT      0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define RCS_MAX_WAIT        2'h3

`endif

/* rtl/rcs_reset_cause.v */
`timescale 1ns/1ps
`include "rcs_defs.vh"

// Functional notes
// (RULE_01) Word, half, byte access; up to three waits
// (RULE_02) Register at 0x38, resets to 0x08000000
// (RULE_03) Low-power reset sets read-only bit 31
// (RULE_04) Watchdog reset sets read-only bit 29
// (RULE_05) Software reset sets read-only bit 28
// (RULE_06) Power-on or power-down reset sets bit 27
// (RULE_07) External pin reset sets bit 26
// (RULE_08) Writing one to bit 24 clears flags
// (RULE_09) CPU lockup reset sets bit 23
// (RULE_10) Flags survive non-power resets, no direct clear
// (RULE_11) Software keeps reserved bits at reset value
// (RULE_12) Bit 7 lets lockup cause system reset
// (RULE_13) Voltage-detector reset sets bit 22
// (RULE_14) Flag set while its reset is applied
module rcs_reset_cause
(
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        power_rst_i,
  input  wire        low_power_rst_i,
  input  wire        watchdog_rst_i,
  input  wire        software_rst_i,
  input  wire        external_reset_pin_n_i,
  input  wire        cpu_lockup_i,
  input  wire        voltage_detector_i,
  input  wire        low_speed_osc_ready_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         lockup_rst_req_o,
  output reg         vdet_rst_req_o,
  output reg         low_speed_osc_on_o
);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  // Sticky reset-cause flags and their next values.
  reg        low_power_reset_flag_r;
  reg        watchdog_reset_flag_r;
  reg        software_reset_flag_r;
  reg        power_on_reset_flag_r;
  reg        pin_reset_flag_r;
  reg        cpu_lockup_reset_flag_r;
  reg        voltage_detector_reset_flag_r;
  reg        low_power_reset_flag_nxt;
  reg        watchdog_reset_flag_nxt;
  reg        software_reset_flag_nxt;
  reg        power_on_reset_flag_nxt;
  reg        pin_reset_flag_nxt;
  reg        cpu_lockup_reset_flag_nxt;
  reg        voltage_detector_reset_flag_nxt;

  // Software control bits and their next values.
  reg        cpu_lockup_reset_enable_r;
  reg        voltage_detector_reset_enable_r;
  reg        low_speed_osc_on_r;
  reg        cpu_lockup_reset_enable_nxt;
  reg        voltage_detector_reset_enable_nxt;
  reg        low_speed_osc_on_nxt;

  // Two-stage synchronisers for the external reset pin and the oscillator-ready level.
  reg [1:0]  pin_sync_r;
  reg [1:0]  lsrdy_sync_r;

  // Bus handshake state, wait counting and gap measurement.
  reg [2:0]  state_r;
  reg [2:0]  state_nxt;
  reg [1:0]  wait_cnt_r;
  reg [1:0]  wait_cnt_nxt;
  reg        prev_hit_r;
  reg        prev_hit_nxt;
  reg [1:0]  gap_cnt_r;
  reg [1:0]  gap_cnt_nxt;
  reg        ack_nxt;
  reg [31:0] rdata_nxt;
  reg [31:0] csr_val;

  wire       hit;
  wire       start;
  wire       wr_done;
  wire       rmv;
  wire       pin_rst;
  wire       lockup_set;
  wire       vdet_set;

  // Handshake states, one-hot.
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_WAIT = 3'h2;
  localparam [2:0] ST_DONE = 3'h4;

  // Byte-lane merge for one bit of a write, used by the two enable bits and the oscillator-on bit.
  function lane_bit;
    input [31:0] old;
    input [31:0] dat;
    input [3:0]  sel;
    input integer pos;
    begin
      lane_bit = sel[pos / 8] ? dat[pos] : old[pos];
    end
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  // The external reset pin passes through two flops; only the second stage drives pin_rst.
  always @(posedge clk_i)
  begin
    pin_sync_r <= {pin_sync_r[0], external_reset_pin_n_i};
  end

  // The oscillator-ready level is synchronised the same way.
  always @(posedge clk_i)
  begin
    lsrdy_sync_r <= {lsrdy_sync_r[0], low_speed_osc_ready_i};
  end

  // The pin is active low; a high value here means the pin holds reset.
  assign pin_rst = ~pin_sync_r[1];

  // --------------------------------------------------------------------------
  // Bus decode and wait states
  // --------------------------------------------------------------------------
  assign hit     = (wb_adr_i == `RCS_CSR_OFFSET);
  assign start   = wb_cyc_i & wb_stb_i & (state_r == ST_IDLE);
  assign wr_done = (state_r == ST_WAIT) & (wait_cnt_r == 2'h0) &
                   wb_we_i & hit;
  // Remove-flags acts only when its lane is enabled and the bit is one.
  assign rmv     = wr_done & wb_sel_i[3] & wb_dat_i[`RCS_REMOVE_BIT]; // [RULE_08]

  // Assembled register image; reserved and write-only bits read zero.
  always @*
  begin
    csr_val                       = 32'h0000_0000;
    csr_val[`RCS_LOW_POWER_BIT]   = low_power_reset_flag_r;
    csr_val[`RCS_WATCHDOG_BIT]    = watchdog_reset_flag_r;
    csr_val[`RCS_SOFTWARE_BIT]    = software_reset_flag_r;
    csr_val[`RCS_POWER_ON_BIT]    = power_on_reset_flag_r;
    csr_val[`RCS_PIN_BIT]         = pin_reset_flag_r;
    csr_val[`RCS_LOCKUP_BIT]      = cpu_lockup_reset_flag_r;
    csr_val[`RCS_VDET_BIT]        = voltage_detector_reset_flag_r;
    csr_val[`RCS_LOCKUP_EN_BIT]   = cpu_lockup_reset_enable_r;
    csr_val[`RCS_VDET_EN_BIT]     = voltage_detector_reset_enable_r;
    csr_val[`RCS_LSO_RDY_BIT]     = lsrdy_sync_r[1];
    csr_val[`RCS_LSO_ON_BIT]      = low_speed_osc_on_r;
  end

  // Handshake next-state logic.  A request is taken only in idle, so the
  // cycle that carries ack can never start a second access by mistake.
  // The gap counter measures cycles since the last ack to any address.
  always @*
  begin
    state_nxt    = state_r;
    wait_cnt_nxt = wait_cnt_r;
    gap_cnt_nxt  = (gap_cnt_r == `RCS_MAX_WAIT) ? gap_cnt_r
                                                : gap_cnt_r + 2'h1;
    prev_hit_nxt = prev_hit_r;
    ack_nxt      = 1'b0;
    rdata_nxt    = wb_dat_o;

    case (state_r)
      ST_IDLE:
      begin
        if (start)
        begin
          state_nxt = ST_WAIT;
          // Successive hits wait three cycles less the gap; a
          // gap of three cycles or more costs no wait at all.
          if (hit && prev_hit_r)
            wait_cnt_nxt = `RCS_MAX_WAIT - gap_cnt_r; // [RULE_01]
          else
            wait_cnt_nxt = 2'h0;
        end
      end
      ST_WAIT:
      begin
        // Count down the inserted wait cycles before answering.
        if (wait_cnt_r != 2'h0)
          wait_cnt_nxt = wait_cnt_r - 2'h1;
        else
        begin
          state_nxt    = ST_DONE;
          ack_nxt      = 1'b1;
          prev_hit_nxt = hit;
          gap_cnt_nxt  = 2'h0;
          // Unmapped addresses read zero and ignore writes.
          rdata_nxt    = (hit && !wb_we_i) ? csr_val : 32'h0000_0000;
        end
      end
      ST_DONE:
      begin
        // Ack stands for one cycle while the master drops its request.
        state_nxt = ST_IDLE;
      end
      default:
      begin
        // Codes that are not one-hot fall back to idle.
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Handshake registers; a system reset returns the bus side to idle.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r    <= ST_IDLE;
      wait_cnt_r <= 2'h0;
      gap_cnt_r  <= 2'h0;
      prev_hit_r <= 1'b0;
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h0000_0000;
    end
    else
    begin
      state_r    <= state_nxt;
      wait_cnt_r <= wait_cnt_nxt;
      gap_cnt_r  <= gap_cnt_nxt;
      prev_hit_r <= prev_hit_nxt;
      wb_ack_o   <= ack_nxt;
      wb_dat_o   <= rdata_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Reset-cause flags
  // --------------------------------------------------------------------------
  // Lockup and detector causes count only while their enable bit is set.
  assign lockup_set = cpu_lockup_i & cpu_lockup_reset_enable_r; // [RULE_12]
  assign vdet_set   = voltage_detector_i & voltage_detector_reset_enable_r;

  // Next value of one sticky flag; a new cause beats remove-flags.
  function flag_next;
    input cur;
    input set;
    input clr;
    begin
      if (set)
        flag_next = 1'b1; // [RULE_14]
      else if (clr)
        flag_next = 1'b0; // [RULE_10]
      else
        flag_next = cur;
    end
  endfunction

  // Next flag values.  A cause is sampled while it is asserted, so a reset
  // that lands in the same cycle as remove-flags is never lost.
  always @*
  begin
    low_power_reset_flag_nxt =
      flag_next(low_power_reset_flag_r, low_power_rst_i, rmv); // [RULE_03]
    watchdog_reset_flag_nxt =
      flag_next(watchdog_reset_flag_r, watchdog_rst_i, rmv); // [RULE_04]
    software_reset_flag_nxt =
      flag_next(software_reset_flag_r, software_rst_i, rmv); // [RULE_05]
    power_on_reset_flag_nxt =
      flag_next(power_on_reset_flag_r, 1'b0, rmv); // [RULE_10]
    pin_reset_flag_nxt =
      flag_next(pin_reset_flag_r, pin_rst, rmv); // [RULE_07]
    cpu_lockup_reset_flag_nxt =
      flag_next(cpu_lockup_reset_flag_r, lockup_set, rmv); // [RULE_09]
    voltage_detector_reset_flag_nxt =
      flag_next(voltage_detector_reset_flag_r, vdet_set, rmv); // [RULE_13]
  end

  // Of the resets only the power reset clears flags; system resets leave them alone.
  // The power-on flag alone comes up set after a power reset.
  always @(posedge clk_i)
  begin
    if (power_rst_i)
    begin
      low_power_reset_flag_r        <= 1'b0;
      watchdog_reset_flag_r         <= 1'b0;
      software_reset_flag_r         <= 1'b0;
      power_on_reset_flag_r         <= 1'b1; // [RULE_02] [RULE_06]
      pin_reset_flag_r              <= 1'b0;
      cpu_lockup_reset_flag_r       <= 1'b0;
      voltage_detector_reset_flag_r <= 1'b0;
    end
    else
    begin
      low_power_reset_flag_r        <= low_power_reset_flag_nxt;
      watchdog_reset_flag_r         <= watchdog_reset_flag_nxt;
      software_reset_flag_r         <= software_reset_flag_nxt;
      power_on_reset_flag_r         <= power_on_reset_flag_nxt;
      pin_reset_flag_r              <= pin_reset_flag_nxt;
      cpu_lockup_reset_flag_r       <= cpu_lockup_reset_flag_nxt;
      voltage_detector_reset_flag_r <= voltage_detector_reset_flag_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Control bits and reset requests
  // --------------------------------------------------------------------------
  // Next control bits; a write changes a bit only when its lane is enabled,
  // so a byte write aimed at remove-flags leaves the enables alone.
  always @*
  begin
    cpu_lockup_reset_enable_nxt       = cpu_lockup_reset_enable_r;
    voltage_detector_reset_enable_nxt = voltage_detector_reset_enable_r;
    low_speed_osc_on_nxt              = low_speed_osc_on_r;
    if (wr_done)
    begin
      cpu_lockup_reset_enable_nxt = lane_bit(csr_val, wb_dat_i, wb_sel_i,
                                             `RCS_LOCKUP_EN_BIT);
      voltage_detector_reset_enable_nxt = lane_bit(csr_val, wb_dat_i,
                                                   wb_sel_i,
                                                   `RCS_VDET_EN_BIT);
      low_speed_osc_on_nxt = lane_bit(csr_val, wb_dat_i, wb_sel_i,
                                      `RCS_LSO_ON_BIT);
    end
  end

  // Enables survive system resets too; only power reset restores them.
  always @(posedge clk_i)
  begin
    if (power_rst_i)
    begin
      cpu_lockup_reset_enable_r       <= 1'b0;
      voltage_detector_reset_enable_r <= 1'b0;
      low_speed_osc_on_r              <= 1'b0;
      lockup_rst_req_o                <= 1'b0;
      vdet_rst_req_o                  <= 1'b0;
      low_speed_osc_on_o              <= 1'b0;
    end
    else
    begin
      cpu_lockup_reset_enable_r       <= cpu_lockup_reset_enable_nxt;
      voltage_detector_reset_enable_r <= voltage_detector_reset_enable_nxt;
      low_speed_osc_on_r              <= low_speed_osc_on_nxt;
      // Lockup raises a system reset only when enabled.
      lockup_rst_req_o   <= lockup_set; // [RULE_12]
      vdet_rst_req_o     <= vdet_set;
      low_speed_osc_on_o <= low_speed_osc_on_r;
    end
  end

endmodule // rcs_reset_cause

/* verification/rcs_reset_cause_asserts.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Bus handshake and reset request checks
// ----------------------------------------------------------------------
module rcs_reset_cause_asserts
(
  input wire        clk_i,
  input wire        rst_i,
  input wire        power_rst_i,
  input wire        cpu_lockup_i,
  input wire        voltage_detector_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        lockup_rst_req_o,
  input wire        vdet_rst_req_o
);
  // All checks share the one clock and pause during bus reset.
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_gated: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
    else $error("ack without a request");
  chk_ack_wait: assert property
    ($rose(wb_cyc_i && wb_stb_i) |-> ##[2:5] wb_ack_o)
    else $error("ack missing within five cycles");
  chk_power_clear: assert property
    (power_rst_i |=> !lockup_rst_req_o && !vdet_rst_req_o)
    else $error("request left high after power reset");
  chk_lockup_gate: assert property
    (!$past(cpu_lockup_i) |-> !lockup_rst_req_o)
    else $error("lockup request without lockup");
  chk_vdet_gate: assert property
    (!$past(voltage_detector_i) |-> !vdet_rst_req_o)
    else $error("detector request without trip");
  chk_unmap_zero: assert property
    (wb_ack_o && !wb_we_i && wb_adr_i != 8'h38 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_ro_bits: assert property
    (wb_ack_o && !wb_we_i && wb_adr_i == 8'h38
     |-> (wb_dat_o & 32'h433f_ff3c) == 32'h0)
    else $error("reserved or remove bit reads as one");
endmodule // rcs_reset_cause_asserts

bind rcs_reset_cause rcs_reset_cause_asserts rcs_reset_cause_asserts_inst
  (.clk_i, .rst_i, .power_rst_i, .cpu_lockup_i, .voltage_detector_i,
   .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
   .lockup_rst_req_o, .vdet_rst_req_o);

/* verification/tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
// ----------------------------------------------------------------------
// Register bus bench for the reset cause block
// ----------------------------------------------------------------------
module tb;
  logic        clk_i = 0;
  logic        rst_i = 1;
  logic        prst = 1;
  logic [5:0]  cz = 0;
  logic        cyc = 0;
  logic        stb = 0;
  logic        we = 0;
  logic [7:0]  adr = 0;
  logic [3:0]  sel = 0;
  logic [31:0] dat = 0;
  logic [31:0] rdat;
  logic [31:0] e;
  wire  [31:0] dat_o;
  wire         ack;
  wire         lreq;
  wire         osc;
  wire         vreq;
  int          miscompares = 0;
  int          checks = 0;
  int          pos[6] = '{31, 29, 28, 26, 23, 22};

  // Free running 20 MHz clock.
  always #25 clk_i = ~clk_i;

  // Cause inputs come from one vector, the pin one inverted.
  rcs_reset_cause rcs_reset_cause_inst (.clk_i, .rst_i, .power_rst_i(prst),
    .low_power_rst_i(cz[0]), .watchdog_rst_i(cz[1]), .software_rst_i(cz[2]),
    .external_reset_pin_n_i(~cz[3]), .cpu_lockup_i(cz[4]),
    .voltage_detector_i(cz[5]), .low_speed_osc_ready_i(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .lockup_rst_req_o(lreq), .vdet_rst_req_o(vreq), .low_speed_osc_on_o(osc));

  // One classic cycle; the request stands until ack is sampled.
  task automatic wb_go(input [7:0] a, input [31:0] d, input [3:0] s,
                       input w);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1 && ++n < 40);
    rdat = dat_o;
    if (n >= 40) miscompares++;
    cyc <= 0;
    stb <= 0;
  endtask

  // Reads a word and compares it.
  task automatic rd(input [7:0] a, input [31:0] x);
    wb_go(a, 32'h0, 4'hf, 1'b0);
    `CHK("read data", x, rdat)
  endtask

  // Holds one reset cause for four cycles.
  task automatic cause(input int i);
    cz <= 6'h01 << i;
    repeat (4) @(posedge clk_i);
    cz <= 0;
    repeat (3) @(posedge clk_i);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic wrap_up;
    $display("Counts: %0d checks, %0d miscompares", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence of register tests.
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    prst <= 0;
    rd(8'h38, 32'h0800_0002);
    rd(8'h3c, 32'h0);
    $display("Test reset values done");
    cause(4);
    rd(8'h38, 32'h0800_0002);
    wb_go(8'h38, 32'h0000_00c1, 4'h1, 1'b1);
    repeat (2) @(posedge clk_i);
    `CHK("osc enable", 1'b1, osc)
    e = 32'h0800_00c3;
    for (int i = 0; i < 6; i++)
    begin
      cause(i);
      e[pos[i]] = 1'b1;
      rd(8'h38, e);
    end
    cz <= 6'h30;
    repeat (3) @(posedge clk_i);
    `CHK("lockup request", 1'b1, lreq)
    `CHK("detector request", 1'b1, vreq)
    cz <= 0;
    $display("Test cause flags done");
    wb_go(8'h38, 32'h0, 4'hf, 1'b1);
    e[7:0] = 8'h02;
    rd(8'h38, e);
    cz <= 6'h30;
    repeat (3) @(posedge clk_i);
    `CHK("lockup gated", 1'b0, lreq)
    `CHK("detector gated", 1'b0, vreq)
    cz <= 0;
    rst_i <= 1;
    @(posedge clk_i);
    rst_i <= 0;
    rd(8'h38, e);
    wb_go(8'h38, 32'h0100_0000, 4'h1, 1'b1);
    rd(8'h38, e);
    wb_go(8'h38, 32'h0100_0000, 4'h8, 1'b1);
    rd(8'h38, 32'h0000_0002);
    prst <= 1;
    @(posedge clk_i);
    prst <= 0;
    rd(8'h38, 32'h0800_0002);
    $display("Test clearing done");
    wrap_up();
  end

  // Cuts a hang short well after the tests should have ended.
  initial
  begin
    repeat (4000) @(posedge clk_i);
    miscompares++;
    wrap_up();
  end
endmodule // tb
